// File: lpmc_pkg.sv
// Package for the low-power mode control block
package lpmc_pkg;
  localparam logic [1:0] LPMC_SEL_RUN = 2'h0;
  localparam logic [1:0] LPMC_SEL_WAIT = 2'h1;
  localparam logic [1:0] LPMC_SEL_DOZE = 2'h2;
  localparam logic [1:0] LPMC_SEL_STOP = 2'h3;
  localparam int LPMC_MOD_W = 8;
  localparam int LPMC_PER_W = 8;
  localparam logic [7:0] LPMC_PER_KEEP = 8'h0f;
  localparam int LPMC_LOCK_CNT_W = 8;
  localparam logic [7:0] LPMC_LOCK_WAIT_MAX = 8'hff;

  typedef enum logic [5:0] {
    LPMC_RUN = 6'h01,
    LPMC_WAIT = 6'h02,
    LPMC_DOZE = 6'h04,
    LPMC_STOP = 6'h08,
    LPMC_RELOCK = 6'h10,
    LPMC_OSCUP = 6'h20
  } lpmc_state_t;
endpackage

// File: lpmc_gate_if.sv
// Interface carrying gate decisions from the mode control to the clock gate
`timescale 1ns/1ps
`default_nettype none
interface lpmc_gate_if;
  logic core_on;
  logic xbar_on;
  logic mod_allow;
  logic per_all;
  logic per_none;
  modport ctrl (output core_on, output xbar_on, output mod_allow, output per_all, output per_none);
  modport gate (input core_on, input xbar_on, input mod_allow, input per_all, input per_none);
endinterface
`default_nettype wire

// File: lpmc_gate.sv
// Registered clock enable generator for the module and peripheral clocks
`timescale 1ns/1ps
`default_nettype none
module lpmc_gate #(
  parameter int MOD_W = lpmc_pkg::LPMC_MOD_W,
  parameter int PER_W = lpmc_pkg::LPMC_PER_W
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Gate decisions
  lpmc_gate_if.gate gi,
  // Software requests
  input wire logic [MOD_W-1:0] mod_req,
  input wire logic [PER_W-1:0] per_req,
  // Enables
  output logic [MOD_W-1:0] mod_en,
  output logic [PER_W-1:0] per_en
);
  typedef struct packed {
    logic [MOD_W-1:0] mod_en;
    logic [PER_W-1:0] per_en;
  } lpmc_gate_st_t;
  lpmc_gate_st_t st, next_st;

  always_comb begin
    next_st = st;
    // Module clocks need a running PLL and at least one bus clock
    next_st.mod_en = (gi.mod_allow && (gi.core_on || gi.xbar_on)) ? mod_req : '0;
    if (gi.per_none) begin
      next_st.per_en = '0;
    end else if (gi.per_all) begin
      next_st.per_en = per_req;
    end else begin
      next_st.per_en = per_req & PER_W'(lpmc_pkg::LPMC_PER_KEEP);
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign mod_en = st.mod_en;
  assign per_en = st.per_en;
endmodule
`default_nettype wire

// File: lpmc_ctrl.sv
// Low-power mode sequencer: mode entry, wakeup, retention and clock gating
`timescale 1ns/1ps
`default_nettype none
module lpmc_ctrl #(
  parameter int MOD_W = lpmc_pkg::LPMC_MOD_W,
  parameter int PER_W = lpmc_pkg::LPMC_PER_W,
  parameter logic [7:0] OSC_WAIT = 8'h10
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Control bits of the clock control register
  input wire logic [1:0] low_power_select,
  input wire logic standby_request_en,
  input wire logic main_osc_powerdown,
  input wire logic usb_pll_en,
  input wire logic [MOD_W-1:0] mod_req,
  input wire logic [PER_W-1:0] per_req,
  // Core and wakeup
  input wire logic wait_for_interrupt,
  input wire logic wakeup_irq,
  input wire logic main_pll_lock,
  // Clock and power controls
  output logic core_clk_en,
  output logic xbar_clk_en,
  output logic main_pll_on,
  output logic usb_pll_on,
  output logic main_oscillator_on,
  output logic slow_oscillator_on,
  output logic slow_clock_input_en,
  output logic [MOD_W-1:0] mod_clk_en,
  output logic [PER_W-1:0] per_clk_en,
  output logic standby_request,
  output logic mem_self_refresh,
  // Status
  output logic [5:0] mode_state
);
  // Keep mask covers at most its own width of peripheral clocks
  if (MOD_W < 1 || PER_W < 1 || PER_W > $bits(lpmc_pkg::LPMC_PER_KEEP)) begin
    $error("lpmc_ctrl: unsupported width");
  end

  typedef struct packed {
    lpmc_pkg::lpmc_state_t fsm;
    logic [lpmc_pkg::LPMC_LOCK_CNT_W-1:0] cnt;
    logic core;
    logic xbar;
    logic pll_main;
    logic pll_usb;
    logic mosc;
    logic slow_in;
    logic sosc;
    logic stby;
    logic sref;
    logic osc_off;
  } lpmc_st_t;
  lpmc_st_t st, next_st;

  lpmc_gate_if gif();

  function automatic lpmc_pkg::lpmc_state_t sel_state(input logic [1:0] sel);
    case (sel)
      lpmc_pkg::LPMC_SEL_WAIT: sel_state = lpmc_pkg::LPMC_WAIT;
      lpmc_pkg::LPMC_SEL_DOZE: sel_state = lpmc_pkg::LPMC_DOZE;
      lpmc_pkg::LPMC_SEL_STOP: sel_state = lpmc_pkg::LPMC_STOP;
      default: sel_state = lpmc_pkg::LPMC_RUN;
    endcase
  endfunction

  always_comb begin
    next_st = st;
    unique case (st.fsm)
      lpmc_pkg::LPMC_RUN: begin
        // Mode latched at the wait-for-interrupt; later writes have no effect
        if (wait_for_interrupt && !wakeup_irq) begin
          next_st.fsm = sel_state(low_power_select);
          next_st.osc_off = main_osc_powerdown;
          next_st.stby = 1'b0;
          if (low_power_select == lpmc_pkg::LPMC_SEL_STOP) begin
            next_st.stby = standby_request_en;
          end
        end
      end
      lpmc_pkg::LPMC_WAIT, lpmc_pkg::LPMC_DOZE: begin
        // Main PLL and oscillator stay up, so return is immediate
        if (wakeup_irq) begin
          next_st.fsm = lpmc_pkg::LPMC_RUN;
        end
      end
      lpmc_pkg::LPMC_STOP: begin
        if (wakeup_irq) begin
          next_st.stby = 1'b0;
          next_st.cnt = '0;
          next_st.fsm = st.osc_off ? lpmc_pkg::LPMC_OSCUP : lpmc_pkg::LPMC_RELOCK;
        end
      end
      lpmc_pkg::LPMC_OSCUP: begin
        next_st.cnt = st.cnt + 8'h01;
        if (st.cnt == OSC_WAIT) begin
          next_st.cnt = '0;
          next_st.fsm = lpmc_pkg::LPMC_RELOCK;
        end
      end
      lpmc_pkg::LPMC_RELOCK: begin
        // Timeout avoids a hang if the PLL never reports lock
        next_st.cnt = st.cnt + 8'h01;
        if (main_pll_lock || st.cnt == lpmc_pkg::LPMC_LOCK_WAIT_MAX) begin
          next_st.fsm = lpmc_pkg::LPMC_RUN;
        end
      end
      default: next_st.fsm = lpmc_pkg::LPMC_RUN;
    endcase

    next_st.core = (next_st.fsm == lpmc_pkg::LPMC_RUN);
    next_st.xbar = (next_st.fsm == lpmc_pkg::LPMC_RUN) ||
                   (next_st.fsm == lpmc_pkg::LPMC_WAIT);
    next_st.pll_main = (next_st.fsm != lpmc_pkg::LPMC_STOP) &&
                       (next_st.fsm != lpmc_pkg::LPMC_OSCUP);
    next_st.pll_usb = usb_pll_en && next_st.pll_main &&
                      (next_st.fsm != lpmc_pkg::LPMC_RELOCK);
    next_st.mosc = !(next_st.fsm == lpmc_pkg::LPMC_STOP && next_st.osc_off);
    next_st.slow_in = next_st.mosc;
    // Slow oscillator keeps the wakeup sources alive in every mode
    next_st.sosc = 1'b1;
    next_st.sref = (next_st.fsm == lpmc_pkg::LPMC_STOP);
    if (next_st.fsm != lpmc_pkg::LPMC_STOP) begin
      next_st.stby = 1'b0;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      st.fsm <= lpmc_pkg::LPMC_RUN;
      st.cnt <= '0;
      st.core <= 1'b1;
      st.xbar <= 1'b1;
      st.pll_main <= 1'b1;
      st.pll_usb <= 1'b0;
      st.mosc <= 1'b1;
      st.slow_in <= 1'b1;
      st.sosc <= 1'b1;
      st.stby <= 1'b0;
      st.sref <= 1'b0;
      st.osc_off <= 1'b0;
    end else begin
      st <= next_st;
    end
  end

  assign gif.core_on = next_st.core;
  assign gif.xbar_on = next_st.xbar;
  assign gif.mod_allow = next_st.pll_main;
  assign gif.per_all = next_st.fsm == lpmc_pkg::LPMC_RUN;
  assign gif.per_none = !next_st.pll_main || next_st.fsm == lpmc_pkg::LPMC_RELOCK;

  lpmc_gate #(.MOD_W(MOD_W), .PER_W(PER_W)) u_gate (
    .sys_clk(sys_clk),
    .rst(rst),
    .gi(gif.gate),
    .mod_req(mod_req),
    .per_req(per_req),
    .mod_en(mod_clk_en),
    .per_en(per_clk_en)
  );

  assign core_clk_en = st.core;
  assign xbar_clk_en = st.xbar;
  assign main_pll_on = st.pll_main;
  assign usb_pll_on = st.pll_usb;
  assign main_oscillator_on = st.mosc;
  assign slow_oscillator_on = st.sosc;
  assign slow_clock_input_en = st.slow_in;
  assign standby_request = st.stby;
  assign mem_self_refresh = st.sref;
  assign mode_state = st.fsm;

  stop_clocks_off_a: assert property (@(posedge sys_clk) disable iff (rst)
    mode_state == lpmc_pkg::LPMC_STOP |-> !main_pll_on && !usb_pll_on && !core_clk_en
      && !xbar_clk_en && mod_clk_en == '0 && per_clk_en == '0)
    else $error("clocks on in stop");
  wait_gates_core_a: assert property (@(posedge sys_clk) disable iff (rst)
    mode_state == lpmc_pkg::LPMC_WAIT |-> !core_clk_en && xbar_clk_en && main_pll_on)
    else $error("wait clocks wrong");
  doze_keeps_pll_a: assert property (@(posedge sys_clk) disable iff (rst)
    mode_state == lpmc_pkg::LPMC_DOZE |-> main_pll_on && main_oscillator_on && !xbar_clk_en)
    else $error("doze clocks wrong");
  static_stop_a: assert property (@(posedge sys_clk) disable iff (rst)
    mode_state == lpmc_pkg::LPMC_STOP && st.osc_off |-> !main_oscillator_on && !slow_clock_input_en)
    else $error("static stop clock running");
  standby_off_a: assert property (@(posedge sys_clk) disable iff (rst)
    standby_request |-> mode_state == lpmc_pkg::LPMC_STOP)
    else $error("standby outside stop");
  standby_follow_a: assert property (@(posedge sys_clk) disable iff (rst)
    mode_state == lpmc_pkg::LPMC_RUN && wait_for_interrupt && !wakeup_irq
      && low_power_select == lpmc_pkg::LPMC_SEL_STOP |=> standby_request == $past(standby_request_en))
    else $error("standby not per enable");
  mode_entry_a: assert property (@(posedge sys_clk) disable iff (rst)
    mode_state == lpmc_pkg::LPMC_RUN && wait_for_interrupt && !wakeup_irq
      && low_power_select == lpmc_pkg::LPMC_SEL_DOZE |=> mode_state == lpmc_pkg::LPMC_DOZE)
    else $error("doze not entered");
  doze_wake_a: assert property (@(posedge sys_clk) disable iff (rst)
    mode_state == lpmc_pkg::LPMC_DOZE && wakeup_irq |=> core_clk_en && xbar_clk_en)
    else $error("doze wake slow");
  self_refresh_a: assert property (@(posedge sys_clk) disable iff (rst)
    mem_self_refresh == (mode_state == lpmc_pkg::LPMC_STOP))
    else $error("self refresh mismatch");
  relock_wait_a: assert property (@(posedge sys_clk) disable iff (rst)
    mode_state == lpmc_pkg::LPMC_RELOCK && !main_pll_lock
      && st.cnt != lpmc_pkg::LPMC_LOCK_WAIT_MAX |=> !core_clk_en)
    else $error("core ungated before lock");
  stop_wake_a: assert property (@(posedge sys_clk) disable iff (rst)
    mode_state == lpmc_pkg::LPMC_STOP && wakeup_irq && !st.osc_off |=> ##[0:256] core_clk_en)
    else $error("stop wake timeout");

  // Clock shape of each mode
  mode_onehot_a: assert property (@(posedge sys_clk) disable iff (rst)
    $onehot(mode_state))
    else $error("mode state not one-hot");
  run_clocks_a: assert property (@(posedge sys_clk) disable iff (rst)
    mode_state == lpmc_pkg::LPMC_RUN |-> core_clk_en && xbar_clk_en && main_pll_on)
    else $error("run clocks wrong");
  doze_gates_a: assert property (@(posedge sys_clk) disable iff (rst)
    mode_state == lpmc_pkg::LPMC_DOZE |-> !core_clk_en && mod_clk_en == '0)
    else $error("doze module clocks on");
  mask_keep_a: assert property (@(posedge sys_clk) disable iff (rst)
    mode_state == lpmc_pkg::LPMC_WAIT || mode_state == lpmc_pkg::LPMC_DOZE
      |-> (per_clk_en & ~PER_W'(lpmc_pkg::LPMC_PER_KEEP)) == '0)
    else $error("peripheral clock outside keep mask");
  wait_mod_a: assert property (@(posedge sys_clk) disable iff (rst)
    mode_state == lpmc_pkg::LPMC_WAIT |-> mod_clk_en == $past(mod_req))
    else $error("wait module clocks wrong");
  run_per_a: assert property (@(posedge sys_clk) disable iff (rst)
    mode_state == lpmc_pkg::LPMC_RUN && !$past(rst) |-> per_clk_en == $past(per_req))
    else $error("run peripheral clocks wrong");
  run_mod_a: assert property (@(posedge sys_clk) disable iff (rst)
    mode_state == lpmc_pkg::LPMC_RUN && !$past(rst) |-> mod_clk_en == $past(mod_req))
    else $error("run module clocks wrong");
  usb_follow_a: assert property (@(posedge sys_clk) disable iff (rst)
    mode_state != lpmc_pkg::LPMC_STOP && mode_state != lpmc_pkg::LPMC_RELOCK
      && mode_state != lpmc_pkg::LPMC_OSCUP && !$past(rst)
      |-> usb_pll_on == $past(usb_pll_en))
    else $error("usb pll not per enable");
  slow_osc_a: assert property (@(posedge sys_clk) disable iff (rst)
    slow_oscillator_on)
    else $error("slow oscillator off");
  osc_running_a: assert property (@(posedge sys_clk) disable iff (rst)
    mode_state != lpmc_pkg::LPMC_STOP |-> main_oscillator_on && slow_clock_input_en)
    else $error("oscillator off outside stop");
  slow_in_a: assert property (@(posedge sys_clk) disable iff (rst)
    mode_state == lpmc_pkg::LPMC_STOP |-> slow_clock_input_en == main_oscillator_on)
    else $error("slow clock input not with oscillator");

  // Entry and retention
  stop_standby_a: assert property (@(posedge sys_clk) disable iff (rst)
    mode_state == lpmc_pkg::LPMC_RUN && wait_for_interrupt && !wakeup_irq && !standby_request_en
      && low_power_select == lpmc_pkg::LPMC_SEL_STOP |=> !standby_request)
    else $error("standby without enable");
  standby_stable_a: assert property (@(posedge sys_clk) disable iff (rst)
    mode_state == lpmc_pkg::LPMC_STOP && $past(mode_state) == lpmc_pkg::LPMC_STOP
      |-> $stable(standby_request))
    else $error("standby changed in stop");
  osc_apply_a: assert property (@(posedge sys_clk) disable iff (rst)
    mode_state == lpmc_pkg::LPMC_RUN && wait_for_interrupt && !wakeup_irq
      && low_power_select == lpmc_pkg::LPMC_SEL_STOP
      |=> main_oscillator_on == !$past(main_osc_powerdown))
    else $error("oscillator power-down not applied");
  wait_entry_a: assert property (@(posedge sys_clk) disable iff (rst)
    mode_state == lpmc_pkg::LPMC_RUN && wait_for_interrupt && !wakeup_irq
      && low_power_select == lpmc_pkg::LPMC_SEL_WAIT |=> mode_state == lpmc_pkg::LPMC_WAIT)
    else $error("wait not entered");
  stop_entry_a: assert property (@(posedge sys_clk) disable iff (rst)
    mode_state == lpmc_pkg::LPMC_RUN && wait_for_interrupt && !wakeup_irq
      && low_power_select == lpmc_pkg::LPMC_SEL_STOP
      |=> mode_state == lpmc_pkg::LPMC_STOP && mem_self_refresh)
    else $error("stop not entered");
  run_stay_a: assert property (@(posedge sys_clk) disable iff (rst)
    mode_state == lpmc_pkg::LPMC_RUN && wait_for_interrupt
      && low_power_select == lpmc_pkg::LPMC_SEL_RUN |=> mode_state == lpmc_pkg::LPMC_RUN)
    else $error("run select left run");
  wake_wins_a: assert property (@(posedge sys_clk) disable iff (rst)
    mode_state == lpmc_pkg::LPMC_RUN && wakeup_irq |=> mode_state == lpmc_pkg::LPMC_RUN)
    else $error("entry despite pending wakeup");

  // Exit paths
  wait_wake_a: assert property (@(posedge sys_clk) disable iff (rst)
    mode_state == lpmc_pkg::LPMC_WAIT && wakeup_irq
      |=> mode_state == lpmc_pkg::LPMC_RUN && core_clk_en)
    else $error("wait wake failed");
  stop_stays_a: assert property (@(posedge sys_clk) disable iff (rst)
    mode_state == lpmc_pkg::LPMC_STOP && !wakeup_irq |=> mode_state == lpmc_pkg::LPMC_STOP)
    else $error("stop left without wakeup");
  stop_osc_exit_a: assert property (@(posedge sys_clk) disable iff (rst)
    mode_state == lpmc_pkg::LPMC_STOP && wakeup_irq && st.osc_off
      |=> mode_state == lpmc_pkg::LPMC_OSCUP && !main_pll_on)
    else $error("static stop exit wrong");
  stop_pll_exit_a: assert property (@(posedge sys_clk) disable iff (rst)
    mode_state == lpmc_pkg::LPMC_STOP && wakeup_irq && !st.osc_off
      |=> mode_state == lpmc_pkg::LPMC_RELOCK && main_pll_on)
    else $error("stop exit wrong");
  oscup_wait_a: assert property (@(posedge sys_clk) disable iff (rst)
    mode_state == lpmc_pkg::LPMC_OSCUP && st.cnt != OSC_WAIT
      |=> mode_state == lpmc_pkg::LPMC_OSCUP)
    else $error("oscillator startup cut short");
  oscup_done_a: assert property (@(posedge sys_clk) disable iff (rst)
    mode_state == lpmc_pkg::LPMC_OSCUP && st.cnt == OSC_WAIT
      |=> mode_state == lpmc_pkg::LPMC_RELOCK)
    else $error("oscillator startup overran");
  oscup_gated_a: assert property (@(posedge sys_clk) disable iff (rst)
    mode_state == lpmc_pkg::LPMC_OSCUP |-> main_oscillator_on && !main_pll_on
      && !core_clk_en && mod_clk_en == '0)
    else $error("clocks on in oscillator startup");
  relock_exit_a: assert property (@(posedge sys_clk) disable iff (rst)
    mode_state == lpmc_pkg::LPMC_RELOCK && main_pll_lock
      |=> mode_state == lpmc_pkg::LPMC_RUN && core_clk_en)
    else $error("lock did not end relock");
  relock_timeout_a: assert property (@(posedge sys_clk) disable iff (rst)
    mode_state == lpmc_pkg::LPMC_RELOCK && st.cnt == lpmc_pkg::LPMC_LOCK_WAIT_MAX
      |=> mode_state == lpmc_pkg::LPMC_RUN)
    else $error("relock timeout missed");
  relock_gated_a: assert property (@(posedge sys_clk) disable iff (rst)
    mode_state == lpmc_pkg::LPMC_RELOCK |-> main_pll_on && !usb_pll_on && !core_clk_en
      && mod_clk_en == '0 && per_clk_en == '0)
    else $error("clocks on before lock");
endmodule
`default_nettype wire

// File: lpmc_pll_model.sv
// Far-side model of the main PLL lock indicator
`timescale 1ns/1ps
`default_nettype none
module lpmc_pll_model (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // PLL control and lock
  input wire logic main_pll_on,
  input wire logic [8:0] lock_delay,
  output logic main_pll_lock
);
  logic [8:0] cnt;
  // Zero delay never locks, to reach the lock timeout path
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      cnt <= 9'h000;
    end else if (!main_pll_on) begin
      cnt <= 9'h000;
    end else if (cnt != 9'h1ff) begin
      cnt <= cnt + 9'h001;
    end
  end
  assign main_pll_lock = main_pll_on && lock_delay != 9'h000 && cnt >= lock_delay;
endmodule
`default_nettype wire

// File: low_power_mode_control_tb.sv
// Self-checking testbench for the low-power mode sequencer
`timescale 1ns/1ps
`default_nettype none
module low_power_mode_control_tb;
  logic sys_clk, rst, standby_request_en, main_osc_powerdown, usb_pll_en;
  logic wait_for_interrupt, wakeup_irq, main_pll_lock;
  logic [1:0] low_power_select;
  logic [7:0] mod_req, per_req, mod_clk_en, per_clk_en;
  logic core_clk_en, xbar_clk_en, main_pll_on, usb_pll_on, main_oscillator_on;
  logic slow_oscillator_on, slow_clock_input_en, standby_request, mem_self_refresh;
  logic [5:0] mode_state;
  logic [8:0] lock_delay;
  int n_fail = 0;
  int comparisons = 0;

  lpmc_ctrl #(.OSC_WAIT(8'h04)) lpmc_ctrl_i (.sys_clk(sys_clk), .rst(rst),
    .low_power_select(low_power_select), .standby_request_en(standby_request_en),
    .main_osc_powerdown(main_osc_powerdown), .usb_pll_en(usb_pll_en), .mod_req(mod_req),
    .per_req(per_req), .wait_for_interrupt(wait_for_interrupt), .wakeup_irq(wakeup_irq),
    .main_pll_lock(main_pll_lock), .core_clk_en(core_clk_en), .xbar_clk_en(xbar_clk_en),
    .main_pll_on(main_pll_on), .usb_pll_on(usb_pll_on),
    .main_oscillator_on(main_oscillator_on), .slow_oscillator_on(slow_oscillator_on),
    .slow_clock_input_en(slow_clock_input_en), .mod_clk_en(mod_clk_en),
    .per_clk_en(per_clk_en), .standby_request(standby_request),
    .mem_self_refresh(mem_self_refresh), .mode_state(mode_state));
  lpmc_pll_model lpmc_pll_model_i (.sys_clk(sys_clk), .rst(rst), .main_pll_on(main_pll_on),
    .lock_delay(lock_delay), .main_pll_lock(main_pll_lock));

  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end

  task automatic close_out();
    $display("comparisons %0d n_fail %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  task automatic chk(string name, logic [31:0] seen, logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // Reference outputs for mode m: 0 run, 1 wait, 2 doze, 3 stop
  function automatic logic [24:0] model(int m);
    logic [7:0] pk;
    pk = (m == 0) ? per_req : (per_req & lpmc_pkg::LPMC_PER_KEEP);
    if (m == 3) return {5'h10, ~main_osc_powerdown, ~main_osc_powerdown,
      standby_request_en, 1'b1, 16'h0000};
    return {1'b1, m == 0, m < 2, 1'b1, usb_pll_en, 2'h3, 2'h0, (m < 2) ? mod_req : 8'h00, pk};
  endfunction

  task automatic check(int m);
    chk("mode_state", 32'(mode_state), 32'(6'h01 << m));
    chk("clocks", 32'({slow_oscillator_on, core_clk_en, xbar_clk_en, main_pll_on, usb_pll_on,
      main_oscillator_on, slow_clock_input_en, standby_request, mem_self_refresh,
      mod_clk_en, per_clk_en}), 32'(model(m)));
  endtask

  // Wakeup not driven here, low except in the refusal test: masked interrupts, source already set up
  task automatic enter(logic [1:0] sel, logic sb, logic od, int m);
    @(posedge sys_clk);
    low_power_select <= sel;
    standby_request_en <= sb;
    main_osc_powerdown <= od;
    usb_pll_en <= 1'($urandom);
    mod_req <= 8'($urandom);
    per_req <= 8'($urandom);
    wait_for_interrupt <= 1'b1;
    @(posedge sys_clk);
    wait_for_interrupt <= 1'b0;
    @(negedge sys_clk);
    check(m);
  endtask

  task automatic wake(int m);
    int n;
    logic bad;
    n = 0;
    bad = 1'b0;
    @(posedge sys_clk);
    wakeup_irq <= 1'b1;
    @(posedge sys_clk);
    wakeup_irq <= 1'b0;
    @(negedge sys_clk);
    if (m == 3) begin
      chk("exit_state", 32'(mode_state), main_osc_powerdown ? 32'h20 : 32'h10);
      chk("exit_mem", 32'({standby_request, mem_self_refresh}), 32'h0);
      while (mode_state !== 6'h01 && n < 400) begin
        if (core_clk_en !== 1'b0 || mod_clk_en !== 8'h00) bad = 1'b1;
        n++;
        @(negedge sys_clk);
      end
      if (n == 400) begin
        n_fail++;
        close_out();
      end
      chk("core_gated", 32'(bad), 32'h0);
      if (lock_delay == 9'h000) chk("timeout", 32'(n >= 255), 32'h1);
      else chk("lock", 32'(main_pll_lock), 32'h1);
    end
    check(0);
    $display("test mode %0d done", m);
  endtask

  initial begin
    rst = 1'b1;
    {low_power_select, standby_request_en, main_osc_powerdown, usb_pll_en} = 5'h00;
    {wait_for_interrupt, wakeup_irq, mod_req, per_req} = 18'h00000;
    lock_delay = 9'h010;
    void'($urandom(85));
    repeat (2) @(posedge sys_clk);
    rst <= 1'b0;
    for (int s = 0; s < 3; s++) begin
      enter(2'(s), 1'b0, 1'b0, s);
      wake(s);
    end
    // Refused: wait for interrupt outside run, select change ignored
    enter(2'h1, 1'b0, 1'b0, 1);
    enter(2'h3, 1'b1, 1'b0, 1);
    wake(1);
    // Refused: wakeup pending beats wait for interrupt
    @(posedge sys_clk);
    wakeup_irq <= 1'b1;
    enter(2'h2, 1'b0, 1'b0, 0);
    @(posedge sys_clk);
    wakeup_irq <= 1'b0;
    $display("test wakeup over wait for interrupt done");
    for (int k = 0; k < 5; k++) begin
      lock_delay <= (k == 4) ? 9'h000 : 9'($urandom_range(40, 1));
      enter(2'h3, k[0], k[1], 3);
      wake(3);
    end
    close_out();
  end
endmodule
`default_nettype wire
